// *** rtl/fdsr_top.sv ***
// Functional notes
// - Bit clock aligns to data via oversampled filtering
// - Slice against mean of minimum and maximum
// - Expected deviation: 2-bit exponent, 4-bit mantissa
// - Shift beyond deviation records transition, recompute level
// - Level valid only after three transitions
// - Averaging length field selects contributing bits; here it only sets the level step weight to 1/2^length
// - Length 00 disables estimation, level is zero
// - Average frequency readable as offset measure
// - Seven-bit strength value, 0 to 106
// - Strength is four times log2 of average
// - Update rate filter clock over two^(avg+1)
// - Filter clock follows decimation field
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fdsr_top #(
	parameter int FREQ_W = 12,
	parameter int AMP_W = 16,
	parameter int OVS = 8
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic signed [FREQ_W-1:0] demod_freq,
	input wire logic [AMP_W-1:0] filter_amp,
	output logic rx_data,
	output logic rx_bit_clk
);
	import fdsr_pkg::*;
	initial begin
		if (FREQ_W < 10 || AMP_W < 2 || AMP_W > 26)
			$error("fdsr_top: unsupported width parameters");
		// Six-bit phase and vote counters bound the oversampling ratio
		if (OVS < 4 || OVS > 63)
			$error("fdsr_top: unsupported oversampling ratio");
	end

	function automatic logic [6:0] log2x4(input logic [AMP_W+3:0] v);
		logic [6:0] r;
		r = 7'h00;
		for (int i = 1; i < AMP_W + 4; i++) begin
			if (v[i])
				r = 7'(LOG_SCALE * i + ((i >= 2) ? int'(v[i-1 -: 2]) : int'(v[0]) * 2));
		end
		if (r > STRENGTH_MAX)
			r = STRENGTH_MAX;
		return r;
	endfunction

	function automatic logic signed [FREQ_W:0] mid(input logic signed [FREQ_W-1:0] a,
		input logic signed [FREQ_W-1:0] b);
		logic signed [FREQ_W:0] s;
		s = (FREQ_W+1)'(a) + (FREQ_W+1)'(b);
		return s >>> 1;
	endfunction

	// Registers
	logic [7:0] freq_correction_ctrl_reg;
	logic [7:0] gain_loop_config_b_reg;
	logic [4:0] channel_decimation_field_reg;
	logic rx_en_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;

	wire [3:0] expected_dev_mantissa = freq_correction_ctrl_reg[MANT_LSB +: 4];
	wire [1:0] expected_dev_exponent = freq_correction_ctrl_reg[EXP_LSB +: 2];
	wire [1:0] slicer_average_length = freq_correction_ctrl_reg[SETTLE_LSB +: 2];
	wire [1:0] strength_average_select = gain_loop_config_b_reg[AVG_LSB +: 2];

	// APB decode: one wait state, unmapped address answers with pslverr
	wire apb_acc = psel && penable && !pready_reg;
	// Writes land on the edge where the master sees pready, never earlier
	wire apb_wr = psel && penable && pready_reg && pwrite;
	wire hit_fc = paddr == ADDR_FREQ_CORR;
	wire hit_gb = paddr == ADDR_GAIN_B;
	wire hit_fl = paddr == ADDR_FILTER;
	wire hit_ct = paddr == ADDR_CTRL;
	wire hit_st = paddr == ADDR_STRENGTH;
	wire hit_fa = paddr == ADDR_FREQ_AVG;
	wire hit_ss = paddr == ADDR_STATUS;
	wire hit_any = hit_fc | hit_gb | hit_fl | hit_ct | hit_st | hit_fa | hit_ss;
	wire wr_fc = apb_wr && hit_fc;
	wire wr_gb = apb_wr && hit_gb;
	wire wr_fl = apb_wr && hit_fl;
	wire wr_ct = apb_wr && hit_ct;
	wire rx_turn_on = wr_ct && pwdata[RX_EN_BIT] && !rx_en_reg;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			freq_correction_ctrl_reg <= FREQ_CORR_RST;
		else if (wr_fc)
			freq_correction_ctrl_reg <= pwdata[7:0];
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			gain_loop_config_b_reg <= GAIN_B_RST;
		else if (wr_gb)
			gain_loop_config_b_reg <= pwdata[7:0];
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			channel_decimation_field_reg <= DEC_RST;
		else if (wr_fl)
			channel_decimation_field_reg <= pwdata[4:0];
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			rx_en_reg <= 1'b0;
		else if (wr_ct)
			rx_en_reg <= pwdata[RX_EN_BIT];
	end

	// Filter clock enable: base divider times decimation plus one
	logic [4:0] base_cnt_reg;
	logic [4:0] dec_cnt_reg;
	wire base_tick = base_cnt_reg == 5'(SAMPLE_DIV - 1);
	wire filt_tick = base_tick && dec_cnt_reg >= channel_decimation_field_reg;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			base_cnt_reg <= 5'h00;
		else
			base_cnt_reg <= base_tick ? 5'h00 : base_cnt_reg + 5'h01;
	end

	// Decimation divider only steps on base ticks, so the filter clock tracks the field
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			dec_cnt_reg <= 5'h00;
		else if (base_tick)
			dec_cnt_reg <= filt_tick ? 5'h00 : dec_cnt_reg + 5'h01;
	end

	// Signal strength averaging
	logic [AMP_W+3:0] amp_acc_reg;
	logic [3:0] amp_cnt_reg;
	logic [6:0] strength_reg;
	wire [3:0] amp_last = 4'((2 << strength_average_select) - 1);
	wire [AMP_W+3:0] amp_sum = amp_acc_reg + (AMP_W+4)'(filter_amp);
	// Shift count kept three bits wide: the longest setting would wrap in two
	wire [AMP_W+3:0] amp_avg = amp_sum >> ({1'b0, strength_average_select} + 3'd1);
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			amp_acc_reg <= '0;
			amp_cnt_reg <= 4'h0;
			strength_reg <= 7'h00;
		end else if (filt_tick) begin
			if (amp_cnt_reg >= amp_last) begin
				// Result only moves at block end, reads never see a partial sum
				strength_reg <= log2x4(amp_avg);
				amp_acc_reg <= '0;
				amp_cnt_reg <= 4'h0;
			end else begin
				amp_acc_reg <= amp_sum;
				amp_cnt_reg <= amp_cnt_reg + 4'h1;
			end
		end
	end

	// Data slicer
	wire signed [FREQ_W-1:0] exp_dev = FREQ_W'({expected_dev_mantissa, 2'b00})
		<< expected_dev_exponent;
	logic signed [FREQ_W-1:0] min_reg;
	logic signed [FREQ_W-1:0] max_reg;
	logic signed [FREQ_W-1:0] ref_reg;
	logic signed [FREQ_W-1:0] level_reg;
	logic signed [FREQ_W-1:0] avg_reg;
	logic [2:0] trans_cnt_reg;
	logic [6:0] bits_cnt_reg;
	logic dir_reg;
	wire signed [FREQ_W:0] diff = (FREQ_W+1)'(demod_freq) - (FREQ_W+1)'(ref_reg);
	wire up_shift = diff > (FREQ_W+1)'(exp_dev);
	wire dn_shift = -diff > (FREQ_W+1)'(exp_dev);
	wire shift = filt_tick && (up_shift && !dir_reg || dn_shift && dir_reg);
	wire signed [FREQ_W-1:0] new_min = dn_shift ? demod_freq : min_reg;
	wire signed [FREQ_W-1:0] new_max = up_shift ? demod_freq : max_reg;
	wire signed [FREQ_W-1:0] new_mid = FREQ_W'(mid(new_min, new_max));
	wire [6:0] bits_need = 7'(8 << slicer_average_length);
	wire est_on = slicer_average_length != 2'b00;
	wire slicer_clear = rx_turn_on || !rx_en_reg;
	wire est_step = shift && trans_cnt_reg >= MIN_TRANSITIONS - 3'h1;
	// Longer settings give the new mean less weight: steadier level, slower lock
	wire signed [FREQ_W:0] lvl_err = (FREQ_W+1)'(new_mid) - (FREQ_W+1)'(level_reg);
	wire signed [FREQ_W:0] lvl_step = lvl_err >>> slicer_average_length;
	wire signed [FREQ_W-1:0] lvl_next = FREQ_W'((FREQ_W+1)'(level_reg) + lvl_step);
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			min_reg <= '0;
			max_reg <= '0;
			ref_reg <= '0;
			trans_cnt_reg <= 3'h0;
			dir_reg <= 1'b0;
		end else if (slicer_clear) begin
			min_reg <= '0;
			max_reg <= '0;
			ref_reg <= '0;
			trans_cnt_reg <= 3'h0;
			dir_reg <= 1'b0;
		end else if (shift) begin
			ref_reg <= demod_freq;
			dir_reg <= up_shift;
			min_reg <= new_min;
			max_reg <= new_max;
			if (trans_cnt_reg < MIN_TRANSITIONS)
				trans_cnt_reg <= trans_cnt_reg + 3'h1;
		end
	end

	// Level and average survive a restart so the offset reading does not drop out
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			bits_cnt_reg <= 7'h00;
			level_reg <= '0;
			avg_reg <= '0;
		end else if (slicer_clear) begin
			bits_cnt_reg <= 7'h00;
		end else if (est_step) begin
			if (bits_cnt_reg < bits_need)
				bits_cnt_reg <= bits_cnt_reg + 7'h01;
			avg_reg <= new_mid;
			level_reg <= (bits_cnt_reg == 7'h00) ? new_mid : lvl_next;
		end
	end
	wire signed [FREQ_W-1:0] slice_level = est_on ? level_reg : '0;
	wire signed [FREQ_W-1:0] avg_view = est_on ? avg_reg : '0;

	// Bit synchronizer: oversampled majority vote, phase reset to 1 on data edges
	logic [5:0] ph_reg;
	logic [5:0] vote_reg;
	logic last_raw_reg;
	logic rx_data_reg;
	logic rx_bit_clk_reg;
	wire raw = demod_freq > slice_level;
	wire edge_seen = filt_tick && raw != last_raw_reg;
	wire ph_end = ph_reg == 6'(OVS - 1);
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ph_reg <= 6'h00;
			vote_reg <= 6'h00;
			last_raw_reg <= 1'b0;
			rx_data_reg <= 1'b0;
			rx_bit_clk_reg <= 1'b0;
		end else if (filt_tick) begin
			last_raw_reg <= raw;
			if (edge_seen)
				ph_reg <= 6'h01;
			else
				ph_reg <= ph_end ? 6'h00 : ph_reg + 6'h01;
			if (ph_end || edge_seen) begin
				rx_data_reg <= vote_reg >= 6'(OVS / 2);
				vote_reg <= {5'h00, raw};
			end else begin
				vote_reg <= vote_reg + {5'h00, raw};
			end
			rx_bit_clk_reg <= ph_reg < 6'(OVS / 2);
		end
	end

	// APB read path
	wire [31:0] rd_mux = hit_fc ? {24'h0, freq_correction_ctrl_reg}
		: hit_gb ? {24'h0, gain_loop_config_b_reg}
		: hit_fl ? {27'h0, channel_decimation_field_reg}
		: hit_ct ? {31'h0, rx_en_reg}
		: hit_st ? {25'h0, strength_reg}
		: hit_fa ? 32'(signed'(avg_view))
		: hit_ss ? {29'h0, trans_cnt_reg}
		: 32'h0;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= apb_acc;
			pslverr_reg <= apb_acc && !hit_any;
		end
	end

	// Read data stays put between reads, so a late sample still sees it
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			prdata_reg <= 32'h0;
		else if (apb_acc && !pwrite)
			prdata_reg <= rd_mux;
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign rx_data = rx_data_reg;
	assign rx_bit_clk = rx_bit_clk_reg;
endmodule
`default_nettype wire

// *** rtl/fdsr_pkg.sv ***
`default_nettype none
package fdsr_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_FREQ_CORR = 8'h00;
	localparam logic [7:0] ADDR_GAIN_B = 8'h04;
	localparam logic [7:0] ADDR_FILTER = 8'h08;
	localparam logic [7:0] ADDR_CTRL = 8'h0c;
	localparam logic [7:0] ADDR_STRENGTH = 8'h10;
	localparam logic [7:0] ADDR_FREQ_AVG = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	// Frequency correction control fields
	localparam int MANT_LSB = 0;
	localparam int EXP_LSB = 4;
	localparam int SETTLE_LSB = 6;
	localparam logic [7:0] FREQ_CORR_RST = 8'h00;
	// Gain config b: strength average select
	localparam int AVG_LSB = 0;
	localparam logic [7:0] GAIN_B_RST = 8'h00;
	// Filter: decimation field
	localparam int DEC_LSB = 0;
	localparam logic [4:0] DEC_RST = 5'h00;
	// Control: receive enable
	localparam int RX_EN_BIT = 0;
	// Signal strength
	localparam logic [6:0] STRENGTH_MAX = 7'h6a;
	localparam int LOG_SCALE = 4;
	// Slicer
	localparam logic [2:0] MIN_TRANSITIONS = 3'h3;
	// Base sample divider to reach the top filter clock (2 x 307.2 kHz)
	localparam int SAMPLE_DIV = 16;
endpackage
`default_nettype wire

// *** sim/fdsr_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module fdsr_chk (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	import fdsr_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	wire logic rd = pready && !pwrite;
	sequence s_acc;
		psel && penable && !pready;
	endsequence
	sequence s_idle;
		!(psel && penable);
	endsequence
	property p_ans;
		s_acc |=> pready;
	endproperty
	property p_pulse;
		pready |=> !pready;
	endproperty
	property p_cause;
		pready |-> $past(psel && penable);
	endproperty
	property p_err;
		pslverr |-> pready;
	endproperty
	property p_unmap;
		rd && paddr > ADDR_STATUS |-> pslverr && prdata == 32'h0;
	endproperty
	property p_max;
		rd && paddr == ADDR_STRENGTH |-> prdata <= {25'h0, STRENGTH_MAX};
	endproperty
	property p_cnt;
		rd && paddr == ADDR_STATUS |-> prdata[31:3] == 29'h0;
	endproperty
	property p_hold;
		s_idle |=> $stable(prdata);
	endproperty
	a_ans: assert property (p_ans) else $error("late answer");
	a_pulse: assert property (p_pulse) else $error("long ready");
	a_cause: assert property (p_cause) else $error("stray ready");
	a_err: assert property (p_err) else $error("stray error");
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	a_max: assert property (p_max) else $error("strength range");
	a_cnt: assert property (p_cnt) else $error("count width");
	a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind fdsr_top fdsr_chk i_chk (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr);
`default_nettype wire

// *** sim/fdsr_tx.sv ***
`timescale 1ns/1ps
`default_nettype none
module fdsr_tx #(
	parameter int BIT_CLKS = 256
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic tx_on,
	output logic signed [11:0] demod_freq
);
	int cnt;
	logic bit_reg;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 0;
			bit_reg <= 1'b0;
		end else if (tx_on) begin
			cnt <= (cnt == BIT_CLKS - 1) ? 0 : cnt + 1;
			bit_reg <= (cnt == BIT_CLKS - 1) ? !bit_reg : bit_reg;
		end
	end
	// Carrier offset of 40 gives a slicer level away from zero
	assign demod_freq = !tx_on ? 12'sd40 : bit_reg ? 12'sd240 : -12'sd160;
endmodule
`default_nettype wire

// *** sim/fdsr_top_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module fdsr_top_tb_top;
	import fdsr_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] e; logic r;} fdsr_row_t;
	fdsr_row_t rows [4] = '{'{ADDR_FREQ_CORR, 32'hff, 1'b0}, '{ADDR_GAIN_B, 32'hff, 1'b0},
		'{ADDR_FILTER, 32'h1f, 1'b0}, '{8'h1c, 32'h0, 1'b1}};
	logic [15:0] amps [3] = '{16'h0100, 16'h0300, 16'hffff};
	logic [31:0] exps [3] = '{32'h20, 32'h26, 32'h3f};
	logic clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, rx_data, rx_bit_clk, err, tx_on = 1'b0;
	logic [15:0] filter_amp = 16'h0000;
	logic signed [11:0] demod_freq;
	int errors = 0, comparisons = 0;
	fdsr_top i_dut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .demod_freq, .filter_amp, .rx_data, .rx_bit_clk);
	fdsr_tx i_tx (.clk_sys, .rst_b, .tx_on, .demod_freq);
	initial begin
		forever #50 clk_sys = !clk_sys;
	end
	task automatic give_verdict();
		if (errors == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			errors++;
			give_verdict();
		end
	endtask
	task automatic mid_bit();
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (i_tx.cnt != 200 && n < 300);
		if (n >= 300) begin
			errors++;
			give_verdict();
		end
	endtask
	task automatic see_clk(input logic v);
		int n;
		n = 0;
		while (rx_bit_clk !== v && n < 300) begin
			@(posedge clk_sys);
			n++;
		end
		cmp({31'h0, rx_bit_clk}, {31'h0, v});
		if (n >= 300)
			give_verdict();
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, 32'hffffffff);
			apb(1'b0, rows[i].a, 32'h0);
			cmp(rd, rows[i].e);
			cmp({31'h0, err}, {31'h0, rows[i].r});
		end
		@(posedge clk_sys);
		rst_b <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		apb(1'b0, ADDR_FREQ_CORR, 32'h0);
		cmp(rd, {24'h0, FREQ_CORR_RST});
		apb(1'b1, ADDR_CTRL, 32'h1);
		apb(1'b1, ADDR_GAIN_B, 32'h3);
		for (int i = 0; i < 3; i++) begin
			filter_amp <= amps[i];
			repeat (1000) @(posedge clk_sys);
			apb(1'b0, ADDR_STRENGTH, 32'h0);
			cmp(rd, exps[i]);
			apb(1'b0, ADDR_STRENGTH, 32'h0);
			cmp(rd, exps[i]);
		end
		apb(1'b1, ADDR_FREQ_CORR, 32'h44);
		tx_on <= 1'b1;
		repeat (2000) @(posedge clk_sys);
		apb(1'b0, ADDR_FREQ_AVG, 32'h0);
		cmp(rd, 32'h28);
		apb(1'b0, ADDR_STATUS, 32'h0);
		cmp(rd, {29'h0, MIN_TRANSITIONS});
		for (int i = 0; i < 2; i++) begin
			mid_bit();
			cmp({31'h0, rx_data}, {31'h0, i_tx.bit_reg});
		end
		see_clk(1'b1);
		see_clk(1'b0);
		apb(1'b1, ADDR_CTRL, 32'h0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		cmp(rd, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h1);
		apb(1'b1, ADDR_FREQ_CORR, 32'h04);
		repeat (1000) @(posedge clk_sys);
		apb(1'b0, ADDR_FREQ_AVG, 32'h0);
		cmp(rd, 32'h0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		cmp(rd, {29'h0, MIN_TRANSITIONS});
		give_verdict();
	end
endmodule
`default_nettype wire
